// >>> design/tpf_fifo.sv
// One 36-bit FIFO with a prefetched head word and two-stage flag outputs.
// Assumes pop is only raised while headValid is high.
`default_nettype none

module tpf_fifo
  import tpf_pkg::*;
#(
  parameter int DEPTH = DEF_DEPTH
)(
  input  wire logic              sys_clk,
  input  wire logic              rst_n,
  input  wire logic              clearReq,
  input  wire logic              wrEn,
  input  wire logic [DATA_W-1:0] wrData,
  input  wire logic              pop,
  input  wire logic [OFF_W-1:0]  aeOff,
  input  wire logic [OFF_W-1:0]  afOff,
  output logic      [DATA_W-1:0] headData,
  output logic                   headValid,
  output logic                   roomNow,
  output tpf_flags_t             flags
);

  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] DEPTH_C = (AW+1)'(DEPTH);

  logic [AW-1:0] wrPtr;
  logic [AW-1:0] rdPtr;
  logic [AW:0]   memCount;
  tpf_flags_t    stage1;
  tpf_flags_t    next_flags;

  // Head register refills as soon as it empties, so fall-through costs nothing
  wire logic        loadHead = (memCount != '0) && (!headValid || pop);
  wire logic        push     = wrEn && roomNow;
  wire logic [AW:0] freeCnt  = DEPTH_C - memCount;
  wire logic [AW+1:0] total  = (AW+2)'(memCount) + (AW+2)'(headValid);

  assign roomNow          = memCount != DEPTH_C;
  assign next_flags.ready = headValid;
  assign next_flags.room  = roomNow;
  assign next_flags.lowN  = !(total <= int'(aeOff));
  assign next_flags.highN = !(int'(freeCnt) <= int'(afOff));

  tpf_mem #(
    .DEPTH (DEPTH),
    .W     (DATA_W)
  ) u_mem (
    .sys_clk (sys_clk),
    .wrEn    (push),
    .wrAddr  (wrPtr),
    .wrData  (wrData),
    .rdEn    (loadHead),
    .rdAddr  (rdPtr),
    .rdData  (headData)
  );

  // ****************************************
  // Pointers and occupancy
  // ****************************************
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n || clearReq)
    begin
      wrPtr     <= '0;
      rdPtr     <= '0;
      memCount  <= '0;
      headValid <= 1'b0;
    end
    else
    begin
      if (push)
        wrPtr <= wrPtr + 1'b1;
      if (loadHead)
        rdPtr <= rdPtr + 1'b1;
      // Push and refill on one edge cancel out
      memCount  <= memCount + (AW+1)'(push) - (AW+1)'(loadHead);
      headValid <= loadHead || (headValid && !pop);
    end
  end

  // ****************************************
  // Flag synchroniser stages
  // ****************************************
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      stage1 <= FLAGS_RST;
      flags  <= FLAGS_RST;
    end
    else
    begin
      stage1 <= next_flags;
      flags  <= stage1;
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  sync_ready_a: assert property (flags.ready == $past(headValid, 2))
    else $error("ready flag not two cycles behind head state");
  sync_room_a: assert property (flags.room == $past(roomNow, 2))
    else $error("room flag not two cycles behind occupancy");
  refuse_full_a: assert property (!roomNow && !loadHead && !clearReq |=>
                                  memCount == $past(memCount))
    else $error("write accepted while full");
  low_water_a: assert property (flags.lowN == !($past(total, 2) <= int'($past(aeOff, 2))))
    else $error("almost-empty flag does not track count");
  clear_empty_a: assert property (clearReq |=> memCount == '0 && !headValid)
    else $error("reset left data behind");

endmodule

`default_nettype wire

// >>> design/tpf_mem.sv
// Simple dual-port word store for one FIFO; read data leave from a register.
// Assumes the caller never reads and writes a location it has not filled.
`default_nettype none

module tpf_mem #(
  parameter int DEPTH = 256,
  parameter int W     = 36
)(
  input  wire logic                     sys_clk,
  input  wire logic                     wrEn,
  input  wire logic [$clog2(DEPTH)-1:0] wrAddr,
  input  wire logic [W-1:0]             wrData,
  input  wire logic                     rdEn,
  input  wire logic [$clog2(DEPTH)-1:0] rdAddr,
  output logic      [W-1:0]             rdData
);

  logic [W-1:0] store [DEPTH];

  always_ff @(posedge sys_clk)
  begin
    if (wrEn)
      store[wrAddr] <= wrData;
    if (rdEn)
      rdData <= store[rdAddr];
  end

endmodule

`default_nettype wire

// >>> design/tpf_top.sv
// Top of the triple-port dual FIFO: side A 36-bit, side B reads, side C writes.
// Assumes all side controls are synchronous to sys_clk; no register bus.
`default_nettype none

module tpf_top
  import tpf_pkg::*;
#(
  parameter int DEPTH = DEF_DEPTH
)(
  input  wire logic              sys_clk,
  input  wire logic              rst_n,
  input  wire logic              full_reset_fifo1_n,
  input  wire logic              full_reset_fifo2_n,
  input  wire logic              flush_reset_fifo1_n,
  input  wire logic              flush_reset_fifo2_n,
  input  wire logic              byte_order_timing_select,
  input  wire logic              serial_offset_load_select_n,
  input  wire logic              serial_offset_in,
  input  wire logic              serialOffsetShift,
  input  wire logic              default_threshold_sel0,
  input  wire logic              default_threshold_sel1,
  input  wire logic              sideBByteSel,
  input  wire logic              sideCByteSel,
  input  wire logic              aEnable,
  input  wire logic              aWrite,
  input  wire logic              aMailSel,
  input  wire logic [DATA_W-1:0] aDataIn,
  output logic      [DATA_W-1:0] aDataOut,
  output logic                   aDataOe,
  input  wire logic              bReadEn,
  input  wire logic              bMailSel,
  output logic      [SIDE_W-1:0] bData,
  input  wire logic              cWriteEn,
  input  wire logic              cMailSel,
  input  wire logic [SIDE_W-1:0] cData,
  output logic                   side_a_empty_ready,
  output logic                   side_b_empty_ready,
  output logic                   side_a_full_room,
  output logic                   side_c_full_room,
  output logic                   side_a_low_water_n,
  output logic                   side_b_low_water_n,
  output logic                   side_a_high_water_n,
  output logic                   side_c_high_water_n,
  output logic                   mailbox1_new_mail_n,
  output logic                   mailbox2_new_mail_n,
  output logic                   lowPowerIdle
);

  // ****************************************
  // Slice helpers
  // ****************************************
  function automatic logic [1:0] slicePos(input logic [1:0] idx, input tpf_cfg_t cfg);
    logic [1:0] last;
    last = cfg.byteMode ? LAST_BYTE : LAST_WORD;
    return cfg.bigEnd ? last - idx : idx;
  endfunction

  function automatic logic [SIDE_W-1:0] sliceOf(input logic [DATA_W-1:0] w,
                                                input logic [1:0] idx, input tpf_cfg_t cfg);
    logic [1:0] pos;
    pos = slicePos(idx, cfg);
    if (cfg.byteMode)
      return {{(SIDE_W-BYTE_W){1'b0}}, w[pos*BYTE_W +: BYTE_W]};
    return w[pos[0]*SIDE_W +: SIDE_W];
  endfunction

  // ****************************************
  // State
  // ****************************************
  tpf_cfg_t          cfgB;
  tpf_cfg_t          cfgC;
  logic              fall_through_timing;
  tpf_offmode_t      offMode;
  logic [OFF_W-1:0]  offsets [OFF_NUM];
  logic              pending [OFF_NUM];
  logic              anyPend;
  logic [1:0]        firstPend;
  logic [OFF_W-1:0]  shiftReg;
  logic [3:0]        bitCnt;
  logic [1:0]        bIdx;
  logic [1:0]        cIdx;
  logic [DATA_W-1:0] cWord;
  logic [DATA_W-1:0] next_cWord;
  logic [SIDE_W-1:0] mailbox1;
  logic [SIDE_W-1:0] mailbox2;
  logic [DATA_W-1:0] head1;
  logic [DATA_W-1:0] head2;
  logic              head1Valid;
  logic              head2Valid;
  logic              room1;
  logic              room2;
  tpf_flags_t        flags1;
  tpf_flags_t        flags2;

  // ****************************************
  // Decode
  // ****************************************
  wire logic mr1  = !rst_n || !full_reset_fifo1_n;
  wire logic mr2  = !rst_n || !full_reset_fifo2_n;
  wire logic clr1 = mr1 || !flush_reset_fifo1_n;
  wire logic clr2 = mr2 || !flush_reset_fifo2_n;

  wire logic [1:0] defSel = {default_threshold_sel1, default_threshold_sel0};
  wire logic [OFF_W-1:0] defOff = (defSel == SEL_8)  ? OFF_DEF_8 :
                                  (defSel == SEL_16) ? OFF_DEF_16 : OFF_DEF_64;
  // Select code 3 with serial mode off asks for parallel loading
  wire tpf_offmode_t startMode = !serial_offset_load_select_n ? OFF_SERIAL :
                                 (defSel > SEL_64) ? OFF_PARALLEL : OFF_DEFAULT;

  wire logic aWr       = aEnable && aWrite && !aMailSel;
  wire logic aOffLoad  = aWr && offMode == OFF_PARALLEL && anyPend;
  wire logic aFifoWr   = aWr && !aOffLoad && room1;
  wire logic aFifoRd   = aEnable && !aWrite && !aMailSel && head2Valid;
  wire logic aMailWr   = aEnable && aWrite && aMailSel;
  wire logic aMailRd   = aEnable && !aWrite && aMailSel;
  wire logic serShift  = serialOffsetShift && offMode == OFF_SERIAL && anyPend;
  wire logic serLoad   = serShift && bitCnt == BIT_LAST;
  wire logic anyLoad   = aOffLoad || serLoad;
  wire logic [OFF_W-1:0] loadData = aOffLoad ? aDataIn[OFF_W-1:0]
                                             : {shiftReg[OFF_W-2:0], serial_offset_in};

  wire logic       bMailRd = bReadEn && bMailSel;
  wire logic       bFifoRd = bReadEn && !bMailSel && head1Valid;
  wire logic [1:0] bLast   = cfgB.byteMode ? LAST_BYTE : LAST_WORD;
  wire logic       pop1    = bFifoRd && bIdx == bLast;

  wire logic       cMailWr = cWriteEn && cMailSel;
  wire logic       cFifoWr = cWriteEn && !cMailSel && room2;
  wire logic [1:0] cLast   = cfgC.byteMode ? LAST_BYTE : LAST_WORD;
  wire logic       push2   = cFifoWr && cIdx == cLast;
  wire logic [1:0] cPos    = slicePos(cIdx, cfgC);

  wire logic activity = aEnable || bReadEn || cWriteEn || serialOffsetShift || clr1 || clr2;

  always_comb
  begin
    anyPend   = 1'b0;
    firstPend = 2'h0;
    for (int i = OFF_NUM - 1; i >= 0; i--)
    begin
      if (pending[i])
      begin
        anyPend   = 1'b1;
        firstPend = 2'(i);
      end
    end
  end

  always_comb
  begin
    next_cWord = cWord;
    if (cfgC.byteMode)
      next_cWord[cPos*BYTE_W +: BYTE_W] = cData[BYTE_W-1:0];
    else
      next_cWord[cPos[0]*SIDE_W +: SIDE_W] = cData;
  end

  // ****************************************
  // FIFOs
  // ****************************************
  tpf_fifo #(.DEPTH (DEPTH)) u_fifo1 (
    .sys_clk   (sys_clk),
    .rst_n     (rst_n),
    .clearReq  (clr1),
    .wrEn      (aFifoWr),
    .wrData    (aDataIn),
    .pop       (pop1),
    .aeOff     (offsets[OFF_AE1]),
    .afOff     (offsets[OFF_AF1]),
    .headData  (head1),
    .headValid (head1Valid),
    .roomNow   (room1),
    .flags     (flags1)
  );

  tpf_fifo #(.DEPTH (DEPTH)) u_fifo2 (
    .sys_clk   (sys_clk),
    .rst_n     (rst_n),
    .clearReq  (clr2),
    .wrEn      (push2),
    .wrData    (next_cWord),
    .pop       (aFifoRd),
    .aeOff     (offsets[OFF_AE2]),
    .afOff     (offsets[OFF_AF2]),
    .headData  (head2),
    .headValid (head2Valid),
    .roomNow   (room2),
    .flags     (flags2)
  );

  // Read side flags belong to the reader, write side flags to the writer
  assign side_a_empty_ready  = flags2.ready;
  assign side_a_low_water_n  = flags2.lowN;
  assign side_c_full_room    = flags2.room;
  assign side_c_high_water_n = flags2.highN;
  assign side_b_empty_ready  = flags1.ready;
  assign side_b_low_water_n  = flags1.lowN;
  assign side_a_full_room    = flags1.room;
  assign side_a_high_water_n = flags1.highN;

  // ****************************************
  // Configuration latched at master reset; timing select tracked outside it
  // ****************************************
  always_ff @(posedge sys_clk)
  begin
    if (mr1)
      cfgB <= '{bigEnd: byte_order_timing_select, byteMode: sideBByteSel};
    if (mr2)
      cfgC <= '{bigEnd: byte_order_timing_select, byteMode: sideCByteSel};
    if (mr1 || mr2)
      offMode <= startMode;
    // Pin is only a timing select once neither FIFO is in master reset
    if (!rst_n)
      fall_through_timing <= 1'b0;
    else if (!mr1 && !mr2)
      fall_through_timing <= !byte_order_timing_select;
  end

  for (genvar i = 0; i < OFF_NUM; i++)
  begin : g_off
    wire logic ownRst = (i % 2 == 0) ? mr1 : mr2;
    always_ff @(posedge sys_clk)
    begin
      if (ownRst)
      begin
        offsets[i] <= (startMode == OFF_DEFAULT) ? defOff : OFF_RESET;
        pending[i] <= startMode != OFF_DEFAULT;
      end
      else if (anyLoad && firstPend == 2'(i))
      begin
        offsets[i] <= loadData;
        pending[i] <= 1'b0;
      end
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (mr1 || mr2)
    begin
      shiftReg <= '0;
      bitCnt   <= '0;
    end
    else if (serShift)
    begin
      shiftReg <= loadData;
      bitCnt   <= serLoad ? 4'h0 : bitCnt + 4'h1;
    end
  end

  // ****************************************
  // Side A
  // ****************************************
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      aDataOut <= '0;
      aDataOe  <= 1'b0;
    end
    else
    begin
      aDataOe <= aEnable && !aWrite;
      if (aMailRd)
        aDataOut <= {{(DATA_W-SIDE_W){1'b0}}, mailbox2};
      else if (aFifoRd || (fall_through_timing && head2Valid))
        aDataOut <= head2;
    end
  end

  // ****************************************
  // Side B
  // ****************************************
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
      bData <= '0;
    else if (bMailRd)
      bData <= mailbox1;
    // Fall-through shows the current slice; standard waits for a read
    else if (bFifoRd || (fall_through_timing && head1Valid))
      bData <= sliceOf(head1, bIdx, cfgB);
    if (clr1)
      bIdx <= 2'h0;
    else if (bFifoRd)
      bIdx <= pop1 ? 2'h0 : bIdx + 2'h1;
  end

  // ****************************************
  // Side C
  // ****************************************
  always_ff @(posedge sys_clk)
  begin
    if (clr2)
    begin
      cIdx  <= 2'h0;
      cWord <= '0;
    end
    else if (cFifoWr)
    begin
      cWord <= next_cWord;
      cIdx  <= push2 ? 2'h0 : cIdx + 2'h1;
    end
  end

  // ****************************************
  // Mailboxes and idle
  // ****************************************
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      mailbox1 <= '0;
      mailbox2 <= '0;
    end
    else
    begin
      if (aMailWr)
        mailbox1 <= cfgB.byteMode ? {{(SIDE_W-BYTE_W){1'b0}}, aDataIn[BYTE_W-1:0]}
                                  : aDataIn[SIDE_W-1:0];
      if (cMailWr)
        mailbox2 <= cfgC.byteMode ? {{(SIDE_W-BYTE_W){1'b0}}, cData[BYTE_W-1:0]} : cData;
    end
    // New mail wins over a read in the same cycle
    if (mr1)
      mailbox1_new_mail_n <= 1'b1;
    else if (aMailWr)
      mailbox1_new_mail_n <= 1'b0;
    else if (bMailRd)
      mailbox1_new_mail_n <= 1'b1;
    if (mr2)
      mailbox2_new_mail_n <= 1'b1;
    else if (cMailWr)
      mailbox2_new_mail_n <= 1'b0;
    else if (aMailRd)
      mailbox2_new_mail_n <= 1'b1;
    lowPowerIdle <= rst_n && !activity;
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  mail_set_a: assert property (aMailWr && full_reset_fifo1_n |=> !mailbox1_new_mail_n)
    else $error("mailbox flag not set by new mail");
  mail_clear_a: assert property (bMailRd && !aMailWr && full_reset_fifo1_n
                                 |=> mailbox1_new_mail_n)
    else $error("mailbox flag not cleared by read");
  std_hold_a: assert property (!fall_through_timing && !bFifoRd && !bMailRd |=> $stable(bData))
    else $error("standard mode output changed without read");
  slice_push_a: assert property (cFifoWr && !clr2 |-> push2 == (cIdx == cLast))
    else $error("word pushed at wrong slice");
  idle_wake_a: assert property (activity |=> !lowPowerIdle)
    else $error("idle held during activity");

endmodule

`default_nettype wire

// >>> inc/tpf_pkg.sv
// Shared constants and types for the triple-port dual FIFO with bus matching.
// Assumes a single clock and a synchronous, active-low reset in every user.
// Contract
// - Two 36-bit FIFOs: A to B, C to A.
// - Sides B, C: word or byte, either endian.
// - Transfers on rising clock, only when enabled.
// - Same-edge read and write handled correctly.
// - Two mailboxes, width follows B/C bus width.
// - Mailbox flag goes low on new mail.
// - Master reset clears pointers, latches offset configuration.
// - Independent master reset per FIFO.
// - Flush reset clears data, keeps offset settings.
// - Standard mode: every word needs a read.
// - Fall-through: first word appears without read.
// - Standard mode flags show empty and full.
// - Fall-through flags show room and output valid.
// - Almost-empty flag tracks words left against threshold.
// - Almost-full flag tracks free room against threshold.
// - Write-side flags pass two synchroniser stages.
// - Read-side flags pass two synchroniser stages.
// - Offsets load in parallel over A or serially.
// - Default thresholds 8, 16, 64 chosen at reset.
// - Idle indication drops one clock after activity.
// - Select high at reset means big-endian.
// - Almost-empty low while count at most offset.
`default_nettype none

package tpf_pkg;

  // ****************************************
  // Widths and sizes
  // ****************************************
  localparam int DATA_W    = 36;
  localparam int SIDE_W    = 18;
  localparam int BYTE_W    = 9;
  localparam int OFF_W     = 10;
  localparam int OFF_NUM   = 4;
  localparam int DEF_DEPTH = 256;

  // ****************************************
  // Offset register slots and defaults
  // ****************************************
  localparam int OFF_AE1 = 0;
  localparam int OFF_AE2 = 1;
  localparam int OFF_AF1 = 2;
  localparam int OFF_AF2 = 3;

  localparam logic [OFF_W-1:0] OFF_DEF_8  = 10'h008;
  localparam logic [OFF_W-1:0] OFF_DEF_16 = 10'h010;
  localparam logic [OFF_W-1:0] OFF_DEF_64 = 10'h040;
  localparam logic [OFF_W-1:0] OFF_RESET  = 10'h000;
  localparam logic [3:0]       BIT_LAST   = 4'h9;

  localparam logic [1:0] SEL_8   = 2'h0;
  localparam logic [1:0] SEL_16  = 2'h1;
  localparam logic [1:0] SEL_64  = 2'h2;

  localparam logic [1:0] LAST_BYTE = 2'h3;
  localparam logic [1:0] LAST_WORD = 2'h1;

  // ****************************************
  // Types
  // ****************************************
  typedef enum logic [1:0] {OFF_DEFAULT, OFF_SERIAL, OFF_PARALLEL} tpf_offmode_t;

  typedef struct packed {
    logic ready;
    logic room;
    logic lowN;
    logic highN;
  } tpf_flags_t;

  typedef struct packed {
    logic bigEnd;
    logic byteMode;
  } tpf_cfg_t;

  localparam tpf_flags_t FLAGS_RST = '{ready: 1'b0, room: 1'b1, lowN: 1'b0, highN: 1'b1};

endpackage

`default_nettype wire

// >>> sim/tb_top.sv
// Self-checking bench for the triple-port dual FIFO against queue models.
// Assumes the package and the side C producer model are compiled first.
`default_nettype none
module tb_top
  import tpf_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic              sys_clk = 1'b0, rst_n = 1'b0, fullRst1N = 1'b1, flush2N = 1'b1;
  logic              sel = 1'b0, bByte = 1'b0, thr0 = 1'b0, cStart = 1'b0;
  logic              aEnable = 1'b0, aWrite = 1'b0, aMailSel = 1'b0;
  logic              bReadEn = 1'b0, bMailSel = 1'b0, cMail = 1'b0, cWriteEn, oe, idle;
  logic              aRdy, bRdy, aRoom, cRoom, aLow, bLow, aHigh, cHigh, mb1, mb2;
  logic [DATA_W-1:0] aDataIn = '0, aDataOut, cWord = '0, w;
  logic [SIDE_W-1:0] bData, cData;
  logic [DATA_W-1:0] q1[$], q2[$];
  int                n_mismatch = 0, checked = 0;

  always #4 sys_clk = ~sys_clk;

  tpf_top #(.DEPTH(256)) DUT (
    .sys_clk(sys_clk), .rst_n(rst_n), .full_reset_fifo1_n(fullRst1N),
    .full_reset_fifo2_n(rst_n), .flush_reset_fifo1_n(rst_n), .flush_reset_fifo2_n(flush2N),
    .byte_order_timing_select(sel), .serial_offset_load_select_n(1'b1),
    .serial_offset_in(1'b0), .serialOffsetShift(1'b0), .default_threshold_sel0(thr0),
    .default_threshold_sel1(1'b0), .sideBByteSel(bByte), .sideCByteSel(bByte),
    .aEnable(aEnable), .aWrite(aWrite), .aMailSel(aMailSel), .aDataIn(aDataIn),
    .aDataOut(aDataOut), .aDataOe(oe), .bReadEn(bReadEn), .bMailSel(bMailSel),
    .bData(bData), .cWriteEn(cWriteEn), .cMailSel(cMail), .cData(cData),
    .side_a_empty_ready(aRdy), .side_b_empty_ready(bRdy), .side_a_full_room(aRoom),
    .side_c_full_room(cRoom), .side_a_low_water_n(aLow), .side_b_low_water_n(bLow),
    .side_a_high_water_n(aHigh), .side_c_high_water_n(cHigh),
    .mailbox1_new_mail_n(mb1), .mailbox2_new_mail_n(mb2), .lowPowerIdle(idle));

  tpf_side_c side_c (.sys_clk(sys_clk), .start(cStart), .word(cWord), .room(cRoom),
    .cWriteEn(cWriteEn), .cData(cData));

  // ****************************************
  // Checking and bus tasks
  // ****************************************
  task automatic chk(input string what, input logic [DATA_W-1:0] seen, exp);
    checked++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic complete_run();
    $display("Comparisons %0d, mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task automatic wait_n(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask

  task automatic aOp(input logic wr, mail, input logic [DATA_W-1:0] d);
    @(posedge sys_clk);
    aEnable  <= 1'b1;
    aWrite   <= wr;
    aMailSel <= mail;
    aDataIn  <= d;
    @(posedge sys_clk);
    aEnable  <= 1'b0;
    #1;
  endtask

  task automatic bOp(input logic mail);
    @(posedge sys_clk);
    bReadEn  <= 1'b1;
    bMailSel <= mail;
    @(posedge sys_clk);
    bReadEn  <= 1'b0;
    #1;
  endtask

  // Pops one model word and checks its n slices in the chosen order
  task automatic bWord(input int n, input logic big);
    logic [DATA_W-1:0] v;
    int                k;
    v = q1.pop_front();
    for (int i = 0; i < n; i++)
    begin
      bOp(1'b0);
      k = big ? n - 1 - i : i;
      chk("bData", DATA_W'(bData), (v >> (k * 36 / n)) & ((36'h1 << (36 / n)) - 1));
    end
  endtask

  task automatic cPut(input logic [DATA_W-1:0] d);
    q2.push_back(d);
    @(posedge sys_clk);
    cStart <= 1'b1;
    cWord  <= d;
    @(posedge sys_clk);
    cStart <= 1'b0;
    wait_n(2);
  endtask

  task automatic aPop();
    aOp(1'b0, 1'b0, '0);
    chk("aDataOut", aDataOut, q2.pop_front());
    chk("aDataOe", oe, 1'b1);
  endtask

  // ****************************************
  // Scenarios
  // ****************************************
  initial
  begin
    wait_n(20000);
    n_mismatch++;
    complete_run();
  end

  initial
  begin
    void'($urandom(32'h0e07));
    repeat (8) @(posedge sys_clk);
    rst_n <= 1'b1;
    sel   <= 1'b1;
    wait_n(3);
    chk("bRdy", bRdy, 1'b0);
    chk("aRoom", aRoom, 1'b1);
    chk("bLow", bLow, 1'b0);
    chk("idle", idle, 1'b1);
    for (int i = 0; i < 10; i++)
    begin
      w = DATA_W'({$urandom, $urandom});
      q1.push_back(w);
      aOp(1'b1, 1'b0, w);
      if (i == 0)
      begin
        chk("idle", idle, 1'b0);
        wait_n(2);
        chk("bRdy", bRdy, 1'b0);
        chk("bData", DATA_W'(bData), 36'h0);
        wait_n(1);
        chk("bRdy", bRdy, 1'b1);
      end
    end
    wait_n(6);
    chk("bLow", bLow, 1'b1);
    chk("aHigh", aHigh, 1'b1);
    for (int i = 0; i < 10; i++)
    begin
      bWord(2, 1'b0);
      if (i < 2)
      begin
        wait_n(5);
        chk("bLow", bLow, 36'(i == 0));
      end
    end
    wait_n(5);
    chk("bRdy", bRdy, 1'b0);
    for (int i = 0; i < 3; i++)
      cPut(DATA_W'({$urandom, $urandom}));
    wait_n(6);
    chk("aLow", aLow, 1'b0);
    chk("cHigh", cHigh, 1'b1);
    aPop();
    aPop();
    w = DATA_W'({$urandom, $urandom});
    aOp(1'b1, 1'b1, w);
    chk("mb1", mb1, 1'b0);
    bOp(1'b1);
    chk("bData", DATA_W'(bData), w & 36'h3ffff);
    chk("mb1", mb1, 1'b1);
    // Both slices go to the mailbox; the last one is what stays
    w = DATA_W'({$urandom, $urandom});
    cMail <= 1'b1;
    cPut(w);
    void'(q2.pop_back());
    cMail <= 1'b0;
    chk("mb2", mb2, 1'b0);
    aOp(1'b0, 1'b1, '0);
    chk("aDataOut", aDataOut, w >> 18);
    chk("mb2", mb2, 1'b1);
    @(posedge sys_clk);
    fullRst1N <= 1'b0;
    bByte     <= 1'b1;
    thr0      <= 1'b1;
    wait_n(2);
    fullRst1N <= 1'b1;
    wait_n(4);
    aPop();
    w = DATA_W'({$urandom, $urandom});
    q1.push_back(w);
    aOp(1'b1, 1'b0, w);
    wait_n(6);
    bWord(4, 1'b1);
    sel <= 1'b0;
    w = DATA_W'({$urandom, $urandom});
    aOp(1'b1, 1'b0, w);
    wait_n(7);
    chk("bData", DATA_W'(bData), w >> 27);
    chk("bRdy", bRdy, 1'b1);
    cPut(DATA_W'({$urandom, $urandom}));
    wait_n(2);
    chk("aDataOut", aDataOut, q2.pop_front());
    @(posedge sys_clk);
    flush2N <= 1'b0;
    @(posedge sys_clk);
    flush2N <= 1'b1;
    wait_n(4);
    chk("aRdy", aRdy, 1'b0);
    w = DATA_W'({$urandom, $urandom});
    cPut(w);
    wait_n(7);
    chk("aDataOut", aDataOut, w);
    complete_run();
  end
endmodule
`default_nettype wire

// >>> sim/tpf_side_c.sv
// Side C producer model: sends each 36-bit word as two 18-bit slices.
// Assumes side C is in word mode, little-endian, on the block's clock.
`default_nettype none
module tpf_side_c (
  input  wire logic        sys_clk,
  input  wire logic        start,
  input  wire logic [35:0] word,
  input  wire logic        room,
  output logic             cWriteEn,
  output logic [17:0]      cData
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] step = 2'h0;
  initial cWriteEn = 1'b0;
  initial cData = 18'h0;
  always @(posedge sys_clk)
  begin
    if (step == 2'h0 && start && room)
    begin
      cWriteEn <= 1'b1;
      cData    <= word[17:0];
      step     <= 2'h1;
    end
    else if (step == 2'h1)
    begin
      cData <= word[35:18];
      step  <= 2'h2;
    end
    else
    begin
      // Idle bus flips each cycle so stale data never looks valid
      cWriteEn <= 1'b0;
      cData    <= ~cData;
      step     <= 2'h0;
    end
  end
endmodule
`default_nettype wire
